// ### design/ioecs_pkg.sv
/*
 * constants, types and maps for the i/o expander configuration sequencer.
 * assumes 32-bit classic wishbone and 16-pin smbus i/o expanders.
 */
package ioecs_pkg;
    localparam int NUM_EXP  = 11;
    localparam int NUM_HP   = 8;
    localparam int EXP_LINK = 8;
    localparam int EXP_ACT  = 9;

    // register byte offsets
    localparam logic [7:0] OFS_ADDR_A = 8'h00;
    localparam logic [7:0] OFS_ADDR_B = 8'h04;
    localparam logic [7:0] OFS_ADDR_C = 8'h08;
    localparam logic [7:0] OFS_SLOT_L = 8'h0C;
    localparam logic [7:0] OFS_SLOT_H = 8'h10;
    localparam logic [7:0] OFS_HPCFG  = 8'h14;
    localparam logic [7:0] OFS_PINSEL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // reset values and disabled-port nibble: per port nibble {ilock, pwr_en, pwr_ind, attn}
    localparam logic [3:0]  SLOT_DFLT  = 4'h5;
    localparam logic [31:0] SLOT_RST   = {8{SLOT_DFLT}};
    localparam logic [15:0] HPCFG_RST  = 16'hFFFF;
    localparam logic [3:0]  NEG_NIBBLE = 4'h3;

    // expander register indices
    localparam logic [2:0] REG_IN_LO  = 3'h0;
    localparam logic [2:0] REG_IN_HI  = 3'h1;
    localparam logic [2:0] REG_OUT_LO = 3'h2;
    localparam logic [2:0] REG_OUT_HI = 3'h3;
    localparam logic [2:0] REG_POL_LO = 3'h4;
    localparam logic [2:0] REG_POL_HI = 3'h5;
    localparam logic [2:0] REG_DIR_LO = 3'h6;
    localparam logic [2:0] REG_DIR_HI = 3'h7;

    localparam logic [2:0] STEP_REG [8] = '{3'h2, 3'h3, 3'h4, 3'h5,
                                            3'h6, 3'h7, 3'h0, 3'h1};
    localparam logic [2:0] STEP_FIRST_ALL = 3'h0;
    localparam logic [2:0] STEP_FIRST_PG  = 3'h2;
    localparam logic [2:0] STEP_LAST_HP   = 3'h7;
    localparam logic [2:0] STEP_LAST_LINK = 3'h5;
    localparam logic [2:0] STEP_LAST_UPD  = 3'h1;

    // direction bytes, 1 = input, and the zero polarity byte
    localparam logic [7:0] DIR_HP   = 8'h0F;
    localparam logic [7:0] DIR_OUT  = 8'h00;
    localparam logic [7:0] DIR_IN   = 8'hFF;
    localparam logic [7:0] POL_NONE = 8'h00;

    // hot-plug port per expander section, PORT_NONE = reserved
    localparam logic [4:0] PORT_NONE = 5'h10;
    localparam logic [4:0] HP_LO_PORT [8] = '{5'h01, 5'h02, 5'h05, 5'h06,
                                              5'h09, 5'h0A, 5'h0D, 5'h0E};
    localparam logic [4:0] HP_HI_PORT [8] = '{5'h03, 5'h04, 5'h07, 5'h08,
                                              5'h0B, 5'h0C, 5'h0F, 5'h10};

    typedef enum logic [1:0] {
        KIND_HP   = 2'h0,
        KIND_LINK = 2'h1,
        KIND_PG   = 2'h2
    } ioecs_kind_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_LOAD  = 4'h2,
        ST_PREP  = 4'h4,
        ST_ISSUE = 4'h8
    } ioecs_state_t;
endpackage

// ### design/ioecs_step_if.sv
/*
 * step request and decoded operation between sequencer and planner.
 * assumes both ends sit on core_clk; the planner is combinational.
 */
`timescale 1ns/10ps
`default_nettype none
interface ioecs_step_if;
    import ioecs_pkg::*;
    ioecs_kind_t kind;
    logic        upd;
    logic [2:0]  step;
    logic [2:0]  op_first;
    logic [2:0]  op_reg;
    logic        op_read;
    logic        op_last;
    modport seq  (output kind, upd, step,
                  input  op_first, op_reg, op_read, op_last);
    modport plan (input  kind, upd, step,
                  output op_first, op_reg, op_read, op_last);
endinterface
`default_nettype wire

// ### design/ioecs_step_plan.sv
/*
 * maps an expander kind and step number to the expander register access.
 * assumes the sequencer walks steps from op_first up to op_last.
 */
`timescale 1ns/10ps
`default_nettype none
module ioecs_step_plan
    import ioecs_pkg::*;
(
    // step port
    ioecs_step_if.plan sp
);
    logic [2:0] last;

    always_comb begin
        sp.op_first = STEP_FIRST_ALL;
        last        = STEP_LAST_HP;
        if (sp.upd) begin
            // refresh writes only the two output bytes
            last = STEP_LAST_UPD;
        end else begin
            unique case (sp.kind)
                KIND_HP: begin
                    last = STEP_LAST_HP; // see [RULE11]
                end
                KIND_LINK: begin
                    last = STEP_LAST_LINK; // see [RULE16]
                end
                KIND_PG: begin
                    sp.op_first = STEP_FIRST_PG; // see [RULE17]
                end
                default: begin
                    last = STEP_LAST_UPD;
                end
            endcase
        end
        sp.op_reg  = STEP_REG[sp.step]; // see [RULE12]
        sp.op_read = (sp.op_reg == REG_IN_LO) ||
                     (sp.op_reg == REG_IN_HI); // see [RULE15]
        sp.op_last = (sp.step == last);
    end
endmodule
`default_nettype wire

// ### design/ioecs_top.sv
/*
 * i/o expander configuration sequencer: wishbone registers, expander
 * output computation and a one-at-a-time smbus transaction sequencer.
 * assumes an smbus master engine on core_clk that takes txn_req and
 * answers with a one-cycle txn_done; all inputs are on core_clk.
 */
// Added by the designer: the register offsets and the Wishbone register port.
// Function
// [RULE1] software or eeprom writes every present expander's bus address
// [RULE2] address fields 0-3, 4-7, 8-10 live in three registers
// [RULE3] no expander transaction starts before eeprom load is done
// [RULE4] writing an address field starts that expander's configuration
// [RULE5] disabled or absent ports get inactive output levels
// [RULE6] attention indicator bit 4 defaults to 1, off
// [RULE7] power indicator bit 5 defaults to 0, on
// [RULE8] power enable bit 6 defaults to 1, on
// [RULE9] interlock bit 7 defaults to 0, off
// [RULE10] sent output levels follow slot and hot-plug config registers
// [RULE11] hot-plug expanders 0-7 run a fixed register sequence
// [RULE12] write output registers 2 then 3 first
// [RULE13] then write zero to polarity registers 4 and 5
// [RULE14] then write direction registers 6 and 7
// [RULE15] finally read input registers 0 and 1
// [RULE16] expanders 8,9: status to 2,3, zero 4,5, all outputs
// [RULE17] expander 10: zero 4,5, all inputs, then read 0,1
// [RULE18] enabled expander differing from internal state is rewritten
// [RULE19] led outputs active low, hot-plug outputs not inverted
// [RULE20] writes are write-byte, reads read-byte, register as command
// [RULE21] one expander sequence and one transaction at a time
`timescale 1ns/10ps
`default_nettype none
module ioecs_top
    import ioecs_pkg::*;
(
    // clock, enable, reset
    input  wire logic        core_clk,
    input  wire logic        ce,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // switch state
    input  wire logic        eeprom_done,
    input  wire logic [15:0] port_present,
    input  wire logic [15:0] link_up,
    input  wire logic [15:0] link_active,
    // smbus master transaction port
    output logic             txn_req,
    output logic      [6:0]  txn_addr,
    output logic      [7:0]  txn_cmd,
    output logic      [7:0]  txn_wdata,
    output logic             txn_read,
    input  wire logic        txn_done,
    input  wire logic [7:0]  txn_rdata
);
    // bus-side state
    logic [7:0]   addr_reg [NUM_EXP];
    logic [7:0]   addr_next [NUM_EXP];
    logic [31:0]  slot_lo_reg, slot_lo_next;
    logic [31:0]  slot_hi_reg, slot_hi_next;
    logic [15:0]  hpcfg_reg, hpcfg_next;
    logic [3:0]   sel_reg, sel_next;
    logic         ack_reg, ack_next;
    logic [31:0]  dat_reg, dat_next;
    logic [10:0]  pend_set;
    // sequencer state
    ioecs_state_t state_reg, state_next;
    logic [3:0]   cur_reg, cur_next;
    logic [2:0]   step_reg, step_next;
    logic         upd_reg, upd_next;
    logic [10:0]  pend_reg, pend_next;
    logic [10:0]  cfgd_reg, cfgd_next;
    logic [15:0]  mirror_reg [NUM_EXP];
    logic [15:0]  mirror_next [NUM_EXP];
    logic [15:0]  pins_reg [NUM_EXP];
    logic [15:0]  pins_next [NUM_EXP];
    logic         req_reg, req_next;
    logic [6:0]   taddr_reg, taddr_next;
    logic [7:0]   tcmd_reg, tcmd_next;
    logic [7:0]   twd_reg, twd_next;
    logic         trd_reg, trd_next;
    // derived
    logic [15:0]  want [NUM_EXP];
    logic [10:0]  conflict;
    logic [15:0]  port_en;
    logic [63:0]  slot_all;
    logic         hit;

    ioecs_step_if sp ();
    ioecs_step_plan u_plan (.sp(sp));

    assign wb_dat_o  = dat_reg;
    assign wb_ack_o  = ack_reg;
    assign txn_req   = req_reg;
    assign txn_addr  = taddr_reg;
    assign txn_cmd   = tcmd_reg;
    assign txn_wdata = twd_reg;
    assign txn_read  = trd_reg;

    assign port_en  = hpcfg_reg & port_present; // see [RULE5]
    assign slot_all = {slot_hi_reg, slot_lo_reg};
    assign hit      = wb_cyc_i & wb_stb_i & ~ack_reg;

    function automatic logic [3:0] hp_nib(input logic [4:0]  p,
                                          input logic [63:0] s,
                                          input logic [15:0] en);
        if (p == PORT_NONE || !en[p[3:0]]) begin
            return NEG_NIBBLE; // see [RULE5]
        end
        return s[{p[3:0], 2'b00} +: 4]; // see [RULE10]
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // output levels each expander should show; on hot-plug expanders bits 0-3 and 8-11 are inputs
    for (genvar e = 0; e < NUM_EXP; e++) begin : g_want
        if (e < NUM_HP) begin : g_hp
            // hot-plug levels pass through uninverted, see [RULE19]
            assign want[e] = {hp_nib(HP_HI_PORT[e], slot_all, port_en),
                              4'h0,
                              hp_nib(HP_LO_PORT[e], slot_all, port_en),
                              4'h0};
        end else if (e == EXP_LINK) begin : g_link
            assign want[e] = ~(link_up & port_en); // see [RULE19]
        end else if (e == EXP_ACT) begin : g_act
            assign want[e] = ~(link_active & port_en); // see [RULE19]
        end else begin : g_pg
            assign want[e] = 16'h0000;
        end
        assign conflict[e] = cfgd_reg[e] &&
                             (mirror_reg[e] != want[e]); // see [RULE18]
    end

    // register bus
    always_comb begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] h;
        a = {addr_reg[3], addr_reg[2], addr_reg[1], addr_reg[0]};
        h = merge({16'h0000, hpcfg_reg}, wb_dat_i, wb_sel_i);
        b = {addr_reg[7], addr_reg[6], addr_reg[5], addr_reg[4]};
        c = {8'h00, addr_reg[10], addr_reg[9], addr_reg[8]};
        for (int i = 0; i < NUM_EXP; i++) begin
            addr_next[i] = addr_reg[i];
        end
        slot_lo_next = slot_lo_reg;
        slot_hi_next = slot_hi_reg;
        hpcfg_next   = hpcfg_reg;
        sel_next     = sel_reg;
        pend_set     = 11'h000;
        ack_next     = hit;
        dat_next     = dat_reg;
        if (hit && wb_we_i) begin
            unique case ({wb_adr_i[7:2], 2'b00})
                OFS_ADDR_A, OFS_ADDR_B, OFS_ADDR_C: begin
                    // each byte lane is one expander's field, except lane 3 of the third register, see [RULE2]
                    for (int l = 0; l < 4; l++) begin
                        for (int r = 0; r < 3; r++) begin
                            if (wb_sel_i[l] && (r * 4 + l < NUM_EXP) &&
                                wb_adr_i[3:2] == r[1:0]) begin
                                addr_next[r*4+l] = wb_dat_i[l*8 +: 8];
                                pend_set[r*4+l]  = 1'b1; // see [RULE4]
                            end
                        end
                    end
                end
                OFS_SLOT_L: slot_lo_next = merge(slot_lo_reg, wb_dat_i,
                                                 wb_sel_i);
                OFS_SLOT_H: slot_hi_next = merge(slot_hi_reg, wb_dat_i,
                                                 wb_sel_i);
                OFS_HPCFG: hpcfg_next = h[15:0];
                OFS_PINSEL: if (wb_sel_i[0]) sel_next = wb_dat_i[3:0];
                default: ;
            endcase
        end
        if (hit && !wb_we_i) begin
            unique case ({wb_adr_i[7:2], 2'b00})
                OFS_ADDR_A: dat_next = a;
                OFS_ADDR_B: dat_next = b;
                OFS_ADDR_C: dat_next = c;
                OFS_SLOT_L: dat_next = slot_lo_reg;
                OFS_SLOT_H: dat_next = slot_hi_reg;
                OFS_HPCFG:  dat_next = {16'h0000, hpcfg_reg};
                OFS_PINSEL: dat_next = {(sel_reg < 4'hB) ?
                                        pins_reg[sel_reg] : 16'h0000,
                                        12'h000, sel_reg};
                OFS_STATUS: dat_next = {9'h000, state_reg != ST_IDLE,
                                        cfgd_reg, pend_reg};
                default:    dat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_EXP; i++) begin
                addr_reg[i] <= 8'h00;
            end
            slot_lo_reg <= SLOT_RST; // see [RULE6] [RULE7] [RULE8] [RULE9]
            slot_hi_reg <= SLOT_RST;
            hpcfg_reg   <= HPCFG_RST;
            sel_reg     <= 4'h0;
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h0000_0000;
        end else if (ce) begin
            for (int i = 0; i < NUM_EXP; i++) begin
                addr_reg[i] <= addr_next[i];
            end
            slot_lo_reg <= slot_lo_next;
            slot_hi_reg <= slot_hi_next;
            hpcfg_reg   <= hpcfg_next;
            sel_reg     <= sel_next;
            ack_reg     <= ack_next;
            dat_reg     <= dat_next;
        end
    end

    // sequencer
    assign sp.kind = (cur_reg < 4'h8) ? KIND_HP :
                     (cur_reg < 4'hA) ? KIND_LINK : KIND_PG;
    assign sp.upd  = upd_reg;
    assign sp.step = step_reg;

    always_comb begin
        state_next = state_reg;
        cur_next   = cur_reg;
        step_next  = step_reg;
        upd_next   = upd_reg;
        pend_next  = pend_reg | pend_set;
        cfgd_next  = cfgd_reg;
        req_next   = req_reg;
        taddr_next = taddr_reg;
        tcmd_next  = tcmd_reg;
        twd_next   = twd_reg;
        trd_next   = trd_reg;
        for (int i = 0; i < NUM_EXP; i++) begin
            mirror_next[i] = mirror_reg[i];
            pins_next[i]   = pins_reg[i];
        end
        unique case (state_reg)
            ST_IDLE: begin
                // full configurations win over refreshes, see [RULE21]
                if (eeprom_done && (pend_reg != 11'h000)) begin // see [RULE3]
                    for (int i = NUM_EXP - 1; i >= 0; i--) begin
                        if (pend_reg[i]) cur_next = i[3:0];
                    end
                    upd_next   = 1'b0;
                    state_next = ST_LOAD;
                end else if (eeprom_done && (conflict != 11'h000)) begin
                    for (int i = NUM_EXP - 1; i >= 0; i--) begin
                        if (conflict[i]) cur_next = i[3:0]; // see [RULE18]
                    end
                    upd_next   = 1'b1;
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // a rewrite during the run sets the bit again: set wins
                pend_next[cur_reg] = pend_set[cur_reg];
                cfgd_next[cur_reg] = 1'b0;
                step_next  = sp.op_first;
                state_next = ST_PREP;
            end
            ST_PREP: begin
                taddr_next = addr_reg[cur_reg][6:0]; // see [RULE20]
                tcmd_next  = {5'h00, sp.op_reg};     // see [RULE20]
                trd_next   = sp.op_read;
                unique case (sp.op_reg)
                    REG_OUT_LO: twd_next = want[cur_reg][7:0];  // see [RULE12]
                    REG_OUT_HI: twd_next = want[cur_reg][15:8]; // see [RULE12]
                    REG_POL_LO, REG_POL_HI: twd_next = POL_NONE; // see [RULE13]
                    REG_DIR_LO, REG_DIR_HI: begin
                        unique case (sp.kind)
                            KIND_HP:   twd_next = DIR_HP;  // see [RULE14]
                            KIND_LINK: twd_next = DIR_OUT; // see [RULE16]
                            default:   twd_next = DIR_IN;  // see [RULE17]
                        endcase
                    end
                    default: twd_next = 8'h00;
                endcase
                req_next   = 1'b1;
                state_next = ST_ISSUE;
            end
            ST_ISSUE: begin
                if (txn_done) begin
                    req_next = 1'b0;
                    if (trd_reg) begin
                        pins_next[cur_reg][tcmd_reg[0]*8 +: 8] =
                            txn_rdata; // see [RULE15]
                    end else if (tcmd_reg[2:0] == REG_OUT_LO) begin
                        mirror_next[cur_reg][7:0] = twd_reg;
                    end else if (tcmd_reg[2:0] == REG_OUT_HI) begin
                        mirror_next[cur_reg][15:8] = twd_reg;
                    end
                    if (sp.op_last) begin
                        cfgd_next[cur_reg] = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        step_next  = step_reg + 3'h1;
                        state_next = ST_PREP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cur_reg   <= 4'h0;
            step_reg  <= 3'h0;
            upd_reg   <= 1'b0;
            pend_reg  <= 11'h000;
            cfgd_reg  <= 11'h000;
            req_reg   <= 1'b0;
            taddr_reg <= 7'h00;
            tcmd_reg  <= 8'h00;
            twd_reg   <= 8'h00;
            trd_reg   <= 1'b0;
            for (int i = 0; i < NUM_EXP; i++) begin
                mirror_reg[i] <= 16'h0000;
                pins_reg[i]   <= 16'h0000;
            end
        end else if (ce) begin
            state_reg <= state_next;
            cur_reg   <= cur_next;
            step_reg  <= step_next;
            upd_reg   <= upd_next;
            pend_reg  <= pend_next;
            cfgd_reg  <= cfgd_next;
            req_reg   <= req_next;
            taddr_reg <= taddr_next;
            tcmd_reg  <= tcmd_next;
            twd_reg   <= twd_next;
            trd_reg   <= trd_next;
            for (int i = 0; i < NUM_EXP; i++) begin
                mirror_reg[i] <= mirror_next[i];
                pins_reg[i]   <= pins_next[i];
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_out_lo_done;
        txn_done && txn_req && !txn_read && txn_cmd == 8'h02;
    endsequence
    sequence s_out_hi_req;
        txn_req && !txn_read && txn_cmd == 8'h03;
    endsequence

    chk_start_gate: assert property ($rose(txn_req) |-> eeprom_done) // see [RULE3]
        else $error("transaction started before eeprom load done");
    chk_addr_pend: assert property (ce && hit && wb_we_i && // see [RULE4]
        wb_sel_i[0] && wb_adr_i == OFS_ADDR_A |=> pend_reg[0])
        else $error("address write did not request configuration");
    chk_req_hold: assert property (ce && txn_req && !txn_done |=>
        txn_req && $stable(txn_cmd) && $stable(txn_wdata)) // see [RULE21]
        else $error("transaction request dropped or changed early");
    chk_out_order: assert property (ce throughout s_out_lo_done
        |-> ##[1:4] s_out_hi_req) // see [RULE12]
        else $error("register 3 write did not follow register 2");
    chk_pol_zero: assert property (txn_req && (txn_cmd == 8'h04 ||
        txn_cmd == 8'h05) |-> txn_wdata == 8'h00 && !txn_read) // see [RULE13]
        else $error("polarity register not written with zero");
    chk_read_regs: assert property (txn_req && txn_read |->
        txn_cmd == 8'h00 || txn_cmd == 8'h01) // see [RULE15]
        else $error("read of a register other than 0 or 1");
    chk_link_dir: assert property (txn_req && cur_reg inside {4'h8, 4'h9}
        && txn_cmd[2:1] == 2'b11 |-> txn_wdata == 8'h00) // see [RULE16]
        else $error("link expander pins not all outputs");
    chk_pg_dir: assert property (txn_req && cur_reg == 4'hA &&
        txn_cmd[2:1] == 2'b11 |-> txn_wdata == 8'hFF) // see [RULE17]
        else $error("power good expander pins not all inputs");
    chk_txn_addr: assert property (txn_req |->
        txn_addr == addr_reg[cur_reg][6:0]) // see [RULE20]
        else $error("transaction not sent to programmed address");
    // data is latched on the edge the request rises, from port_en of the cycle before, so require port_en stable
    chk_off_nibble: assert property ($rose(txn_req) && // see [RULE5]
        cur_reg < 4'h8 && txn_cmd[7:1] == 7'h01 && $stable(port_en) &&
        !port_en[txn_cmd[0] ? HP_HI_PORT[cur_reg[2:0]][3:0] :
                 HP_LO_PORT[cur_reg[2:0]][3:0]] |->
        txn_wdata[7:4] == 4'h3)
        else $error("disabled port outputs not at inactive levels");
endmodule
`default_nettype wire

// ### testbench/ioecs_smb_model.sv
/*
 * stand-in for the smbus master engine and the expanders behind it.
 * assumes txn_req holds its fields until the edge after txn_done.
 */
`timescale 1ns/10ps
`default_nettype none
module ioecs_smb_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // transaction port
    input  wire logic       txn_req,
    input  wire logic [3:0] delay,
    output logic            txn_done,
    output logic      [7:0] txn_rdata
);
    logic [3:0] cnt;
    logic       served;
    // read byte toggles outside the answer cycle so stale data matches only on every second cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt       <= 4'h0;
            served    <= 1'h0;
            txn_done  <= 1'h0;
            txn_rdata <= 8'h00;
        end else begin
            txn_done  <= 1'h0;
            txn_rdata <= ~txn_rdata;
            if (!txn_req) begin
                cnt    <= 4'h0;
                served <= 1'h0;
            end else if (!served && cnt >= delay) begin
                txn_done  <= 1'h1;
                txn_rdata <= 8'hC3;
                served    <= 1'h1;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/ioecs_top_tb_top.sv
/*
 * self-checking bench for the expander configuration sequencer.
 * assumes the smbus stand-in answers every transaction it sees.
 */
`timescale 1ns/10ps
`default_nettype none
module ioecs_top_tb_top;
    logic        core_clk, ce, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        eeprom_done, txn_req, txn_read, txn_done;
    logic [7:0]  wb_adr_i, txn_cmd, txn_wdata, txn_rdata;
    logic [3:0]  wb_sel_i, dly;
    logic [31:0] wb_dat_i, wb_dat_o, rv;
    logic [15:0] port_present, link_up, link_active;
    logic [6:0]  txn_addr, cur;
    int          err_count, check_count;
    typedef struct {logic [7:0] a; logic [31:0] v;} ioecs_row_t;
    ioecs_row_t rows [4] = '{'{8'h00, 32'h0}, '{8'h0C, 32'h55555555},
                             '{8'h14, 32'hFFFF}, '{8'h20, 32'h0}};
    ioecs_top dut (.core_clk, .ce, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .eeprom_done,
        .port_present, .link_up, .link_active, .txn_req, .txn_addr,
        .txn_cmd, .txn_wdata, .txn_read, .txn_done, .txn_rdata);
    ioecs_smb_model smb (.core_clk, .rst, .txn_req, .delay(dly), .txn_done,
        .txn_rdata);
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        if (n >= 50) begin
            err_count++;
            wrap_up;
        end
        rv = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge core_clk);
    endtask
    task automatic txn(input logic [7:0] c, d);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(txn_req === 1'h1 && txn_done === 1'h1) && n < 300);
        if (n >= 300) begin
            err_count++;
            wrap_up;
        end
        chk("txn_cmd", txn_cmd, c);
        chk("txn_addr", txn_addr, cur);
        chk("txn_read", txn_read, c < 8'h02);
        if (c > 8'h01) chk("txn_wdata", txn_wdata, d);
    endtask
    task automatic run(input int cnt, input logic [63:0] c, w);
        for (int k = 0; k < cnt; k++)
            txn(c[8*k+:8], w[8*k+:8]);
    endtask
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {ce, rst, wb_cyc_i, wb_stb_i, wb_we_i, eeprom_done} = 6'h30;
        {wb_adr_i, wb_sel_i, wb_dat_i, dly} = '0;
        {port_present, link_up, link_active} = {16'hFFFF, 16'h00F0, 16'h0};
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        chk("txn_req", txn_req, 0);
        for (int i = 0; i < 4; i++) begin
            wb(1'h0, rows[i].a, 4'hF, 32'h0);
            chk("reset value", rv, rows[i].v);
        end
        wb(1'h1, 8'h0C, 4'hF, 32'h55555595);
        wb(1'h1, 8'h14, 4'hF, 32'hFFF7);
        cur = 7'h21;
        wb(1'h1, 8'h00, 4'h1, 32'h21);
        repeat (30) begin
            @(posedge core_clk);
            chk("txn_req", txn_req, 0);
        end
        eeprom_done <= 1'h1;
        run(8, 64'h0100070605040302, 64'h00000F0F00003090);
        wb(1'h0, 8'h00, 4'hF, 32'h0);
        chk("addr a", rv, 32'h21);
        // stand-in answers every read with C3, so both pin bytes hold it
        wb(1'h0, 8'h18, 4'hF, 32'h0);
        chk("pins", rv, 32'hC3C30000);
        wb(1'h0, 8'h1C, 4'hF, 32'h0);
        chk("status", rv, 32'h00000800);
        dly <= 4'h7;
        wb(1'h1, 8'h08, 4'h7, 32'h004A1211);
        cur = 7'h11;
        run(6, 64'h070605040302, 64'hFF0F);
        cur = 7'h12;
        run(6, 64'h070605040302, 64'hFFFF);
        cur = 7'h4A;
        run(6, 64'h010007060504, 64'hFFFF0000);
        wb(1'h0, 8'h08, 4'hF, 32'h0);
        chk("addr c", rv, 32'h004A1211);
        link_up <= 16'h0;
        cur = 7'h11;
        run(2, 64'h0302, 64'hFFFF);
        wrap_up;
    end
endmodule
`default_nettype wire
